// *** src/sssd_pkg.sv ***
/*
 * Constants for the slot status display sequencer: timing, glyph codes,
 * modes and button indices.
 * Assumes a 125 MHz core clock and a five-digit seven-segment display.
 */
// Behaviour
// - Drive a five-digit seven-segment display with unit status.
// - After reset, auto-scroll interface then drive units, every 2 seconds.
// - Scrolling skips slots with no drive unit installed.
// - Set press during scroll stops scrolling and holds current unit.
// - In fixed mode up or down moves to next or previous occupied slot.
// - In scroll mode, mode held 2s toggles normal and unit screens.
// - Normal drive view shows slot and servo-off or servo-on glyph.
// - Unit alarm replaces its normal status with its number.
// - Alarm view shows slot or interface glyph, alarm marker and two-digit number.
// - Digits flash while an alarm is active, drive or interface.
// - Test-operation status shown when unit is in any test operation.
// - Test view shows slot, test marker, servo glyph, decimal point.
// - Each mode, up or down press on unit screens steps screen.
package sssd_pkg;
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned SCROLL_S       = 2;
    localparam int unsigned LONG_PRESS_S   = 2;
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned DEBOUNCE_MS    = 10;
    localparam int unsigned SCROLL_CYC     = CLK_HZ * SCROLL_S;
    localparam int unsigned LONG_CYC       = CLK_HZ * LONG_PRESS_S;
    localparam int unsigned FLASH_CYC      = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int unsigned SLOTS          = 8;
    localparam int unsigned SCREENS        = 4;
    localparam int unsigned BTN_SET        = 0;
    localparam int unsigned BTN_UP         = 1;
    localparam int unsigned BTN_DOWN       = 2;
    localparam int unsigned BTN_MODE       = 3;
    // Segment codes, bit order g..a, active high.
    localparam logic [6:0]  SEG_BLANK      = 7'h00;
    localparam logic [6:0]  SEG_OFF_GLYPH  = 7'h39;
    localparam logic [6:0]  SEG_ON_GLYPH   = 7'h5e;
    localparam logic [6:0]  SEG_ALARM      = 7'h77;
    localparam logic [6:0]  SEG_TEST       = 7'h78;
    localparam logic [6:0]  SEG_IFU        = 7'h71;
    localparam logic [6:0]  SEG_DASH       = 7'h40;
    localparam logic [6:0]  SEG_SCREEN     = 7'h6d;
    typedef enum logic [0:0] {SSSD_SCROLL, SSSD_FIXED} sssd_mode_e;
endpackage

// *** src/sssd_top.sv ***
/*
 * Slot status display sequencer. Collects the interface unit status and
 * the status of each slot, sequences them and drives five digits.
 * Assumes buttons are raw asynchronous pins, active high, and unit status
 * inputs are synchronous to core_clk_in.
 */
module sssd_top
    import sssd_pkg::*;
#(
    parameter int unsigned NSLOT      = sssd_pkg::SLOTS,
    parameter int unsigned SCROLL_T   = sssd_pkg::SCROLL_CYC,
    parameter int unsigned LONG_T     = sssd_pkg::LONG_CYC,
    parameter int unsigned FLASH_T    = sssd_pkg::FLASH_CYC,
    parameter int unsigned DEBOUNCE_T = sssd_pkg::DEBOUNCE_CYC
) (
    input  wire logic              core_clk_in,
    input  wire logic              resetn_in,
    input  wire logic [3:0]        button_in,
    input  wire logic [NSLOT-1:0]  slot_present_in,
    input  wire logic [NSLOT-1:0]  servo_enable_command_in,
    input  wire logic [NSLOT-1:0]  slot_test_in,
    input  wire logic [NSLOT-1:0]  slot_alarm_in,
    input  wire logic [NSLOT*8-1:0] slot_alarm_num_in,
    input  wire logic              ifu_alarm_in,
    input  wire logic [7:0]        ifu_alarm_num_in,
    output logic [34:0]            seg_out,
    output logic [4:0]             dp_out,
    output logic                   unit_screen_out,
    output logic [3:0]             shown_unit_out
);
    import sssd_pkg::*;

    localparam int SW = $clog2(NSLOT + 1);

    logic       rst_s1_reg, rst_n;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    function automatic logic [6:0] hex_seg(input logic [3:0] v);
        logic [6:0] s;
        s = SEG_BLANK;
        case (v)
            4'h0:    s = 7'h3f;
            4'h1:    s = 7'h06;
            4'h2:    s = 7'h5b;
            4'h3:    s = 7'h4f;
            4'h4:    s = 7'h66;
            4'h5:    s = 7'h6d;
            4'h6:    s = 7'h7d;
            4'h7:    s = 7'h07;
            4'h8:    s = 7'h7f;
            4'h9:    s = 7'h6f;
            4'ha:    s = 7'h77;
            4'hb:    s = 7'h7c;
            4'hc:    s = 7'h39;
            4'hd:    s = 7'h5e;
            4'he:    s = 7'h79;
            default: s = 7'h71;
        endcase
        return s;
    endfunction

    // Debounce: three flip-flops, then a stable count before the level is accepted.
    logic [3:0] b1_reg, b2_reg, b3_reg, bst_reg, bst_next, press;
    logic [3:0][31:0] dcnt_reg, dcnt_next;
    always_comb begin
        bst_next  = bst_reg;
        dcnt_next = dcnt_reg;
        for (int i = 0; i < 4; i++) begin
            if (b2_reg[i] != b3_reg[i] || b3_reg[i] == bst_reg[i]) begin
                dcnt_next[i] = 32'h0;
            end else if (dcnt_reg[i] >= DEBOUNCE_T - 1) begin
                dcnt_next[i] = 32'h0;
                bst_next[i]  = b3_reg[i];
            end else begin
                dcnt_next[i] = dcnt_reg[i] + 32'h1;
            end
        end
        press = bst_next & ~bst_reg;
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            b1_reg   <= 4'h0;
            b2_reg   <= 4'h0;
            b3_reg   <= 4'h0;
            bst_reg  <= 4'h0;
            dcnt_reg <= '0;
        end else begin
            b1_reg   <= button_in;
            b2_reg   <= b1_reg;
            b3_reg   <= b2_reg;
            bst_reg  <= bst_next;
            dcnt_reg <= dcnt_next;
        end
    end

    // Unit 0 is the interface unit, units 1..NSLOT are slots.
    function automatic logic [SW-1:0] next_unit(input logic [SW-1:0] u,
                                                input logic [NSLOT-1:0] p,
                                                input logic with_ifu);
        logic [SW-1:0] r;
        logic          found;
        r     = '0;
        found = 1'b0;
        for (int k = 1; k <= NSLOT + 1; k++) begin
            int c;
            c = (int'(u) + k) % (NSLOT + 1);
            if (!found && ((c == 0 && with_ifu) || (c != 0 && p[c-1]))) begin
                r     = SW'(c);
                found = 1'b1;
            end
        end
        return found ? r : u;
    endfunction

    function automatic logic [SW-1:0] prev_unit(input logic [SW-1:0] u,
                                                input logic [NSLOT-1:0] p);
        logic [SW-1:0] r;
        logic          found;
        r     = u;
        found = 1'b0;
        for (int k = 1; k <= NSLOT; k++) begin
            int c;
            c = (int'(u) + NSLOT + 1 - k) % (NSLOT + 1);
            if (!found && c != 0 && p[c-1]) begin
                r     = SW'(c);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    sssd_mode_e    mode_reg, mode_next;
    logic [SW-1:0] unit_reg, unit_next;
    logic [31:0]   tick_reg, tick_next, hold_reg, hold_next, fl_reg, fl_next;
    logic          scr_reg, scr_next, long_done_reg, long_done_next;
    logic          flash_reg, flash_next;
    logic [1:0]    page_reg, page_next;

    always_comb begin
        mode_next      = mode_reg;
        unit_next      = unit_reg;
        tick_next      = tick_reg + 32'h1;
        hold_next      = bst_reg[BTN_MODE] ? hold_reg + 32'h1 : 32'h0;
        long_done_next = bst_reg[BTN_MODE] ? long_done_reg : 1'b0;
        scr_next       = scr_reg;
        page_next      = page_reg;
        fl_next        = fl_reg + 32'h1;
        flash_next     = flash_reg;
        if (fl_reg >= FLASH_T - 1) begin
            fl_next    = 32'h0;
            flash_next = ~flash_reg;
        end
        // A slot that drops out while shown is left for the next unit, the interface or an occupied slot.
        if (unit_reg != '0 && !slot_present_in[unit_reg-1]) begin
            unit_next = next_unit(unit_reg, slot_present_in, 1'b1);
        end
        if (mode_reg == SSSD_SCROLL && !scr_reg) begin
            if (tick_reg >= SCROLL_T - 1) begin
                tick_next = 32'h0;
                unit_next = next_unit(unit_reg, slot_present_in, 1'b1);
            end
            if (press[BTN_SET]) begin
                mode_next = SSSD_FIXED;
            end
        end else if (mode_reg == SSSD_FIXED && !scr_reg) begin
            tick_next = 32'h0;
            if (press[BTN_UP]) begin
                unit_next = next_unit(unit_reg, slot_present_in, 1'b0);
            end else if (press[BTN_DOWN]) begin
                unit_next = prev_unit(unit_reg, slot_present_in);
            end
        end else begin
            tick_next = 32'h0;
            if (press[BTN_UP] || press[BTN_MODE]) begin
                page_next = page_reg + 2'h1;
            end else if (press[BTN_DOWN]) begin
                page_next = page_reg - 2'h1;
            end
        end
        if (mode_reg == SSSD_SCROLL && !long_done_reg && hold_reg >= LONG_T - 1) begin
            long_done_next = 1'b1;
            scr_next       = ~scr_reg;
            page_next      = 2'h0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg      <= SSSD_SCROLL;
            unit_reg      <= '0;
            tick_reg      <= 32'h0;
            hold_reg      <= 32'h0;
            long_done_reg <= 1'b0;
            scr_reg       <= 1'b0;
            page_reg      <= 2'h0;
            fl_reg        <= 32'h0;
            flash_reg     <= 1'b0;
        end else begin
            mode_reg      <= mode_next;
            unit_reg      <= unit_next;
            tick_reg      <= tick_next;
            hold_reg      <= hold_next;
            long_done_reg <= long_done_next;
            scr_reg       <= scr_next;
            page_reg      <= page_next;
            fl_reg        <= fl_next;
            flash_reg     <= flash_next;
        end
    end

    // Display composition.
    logic [34:0] seg_next, seg_reg;
    logic [4:0]  dp_next, dp_reg;
    logic        alm;
    logic [7:0]  anum;
    logic [3:0]  slot_no;
    always_comb begin
        slot_no  = 4'(unit_reg);
        alm      = (unit_reg == '0) ? ifu_alarm_in : slot_alarm_in[unit_reg-1];
        anum     = (unit_reg == '0) ? ifu_alarm_num_in
                                    : slot_alarm_num_in[(unit_reg-1)*8 +: 8];
        seg_next = {5{SEG_BLANK}};
        dp_next  = 5'h00;
        if (alm) begin
            // Alarm content wins on every screen until the unit clears it.
            seg_next = {(unit_reg == '0) ? SEG_IFU : hex_seg(slot_no), SEG_ALARM,
                        SEG_BLANK, hex_seg(anum[7:4]), hex_seg(anum[3:0])};
            if (flash_reg) begin
                seg_next = {5{SEG_BLANK}};
            end
        end else if (scr_reg) begin
            seg_next = {SEG_SCREEN, hex_seg({2'h0, page_reg}), SEG_BLANK,
                        SEG_BLANK, hex_seg(slot_no)};
        end else if (unit_reg == '0) begin
            seg_next = {SEG_IFU, SEG_DASH, SEG_DASH, SEG_DASH, SEG_DASH};
        end else if (slot_test_in[unit_reg-1]) begin
            seg_next = {hex_seg(slot_no), SEG_TEST, SEG_BLANK,
                        servo_enable_command_in[unit_reg-1] ? SEG_ON_GLYPH : SEG_OFF_GLYPH,
                        hex_seg(slot_no)};
            dp_next  = 5'h01;
        end else begin
            seg_next = {hex_seg(slot_no), SEG_BLANK, SEG_BLANK,
                        servo_enable_command_in[unit_reg-1] ? SEG_ON_GLYPH : SEG_OFF_GLYPH,
                        hex_seg(slot_no)};
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            seg_reg <= {5{SEG_BLANK}};
            dp_reg  <= 5'h00;
        end else begin
            seg_reg <= seg_next;
            dp_reg  <= dp_next;
        end
    end
    assign seg_out         = seg_reg;
    assign dp_out          = dp_reg;
    assign unit_screen_out = scr_reg;
    assign shown_unit_out  = 4'(unit_reg);

    a_set_fixes_mode: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (mode_reg == SSSD_SCROLL && !scr_reg && press[BTN_SET]) |=> mode_reg == SSSD_FIXED)
        else $error("set press did not enter fixed mode");
    a_fixed_stays: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        mode_reg == SSSD_FIXED |=> mode_reg == SSSD_FIXED)
        else $error("fixed mode left");
    a_scroll_skips_empty: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (unit_reg != '0 && $changed(unit_reg)) |-> slot_present_in[unit_reg-1])
        else $error("empty slot shown");
    a_scroll_step: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (mode_reg == SSSD_SCROLL && !scr_reg && tick_reg < SCROLL_T - 1 &&
         (unit_reg == '0 || slot_present_in[unit_reg-1])) |=> $stable(unit_reg))
        else $error("scroll stepped early");
    a_fixed_up_moves: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (mode_reg == SSSD_FIXED && !scr_reg && press[BTN_UP] && slot_present_in != '0 &&
         (unit_reg == '0 || slot_present_in[unit_reg-1])) |=> unit_reg != '0)
        else $error("up press did not select a slot");
    a_alarm_number: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (alm && !flash_reg) |=> seg_reg[13:7] == hex_seg(4'($past(anum) >> 4)))
        else $error("alarm number not shown");
    a_alarm_flash: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (alm && flash_reg) |=> seg_reg == {5{SEG_BLANK}})
        else $error("alarm digits not flashing");
    a_test_point: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (!alm && !scr_reg && unit_reg != '0 && slot_test_in[unit_reg-1]) |=> dp_reg == 5'h01)
        else $error("test decimal point missing");
    a_long_toggle: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (mode_reg == SSSD_SCROLL && !long_done_reg && hold_reg >= LONG_T - 1)
        |=> scr_reg != $past(scr_reg))
        else $error("long mode press did not toggle");
endmodule

// *** verification/sssd_partner_model.sv ***
/*
 * Operator push-button model for the slot status display sequencer.
 * Assumes the bench sets the wanted button levels just after a rising edge.
 */
module sssd_partner_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] want_in,
    output logic      [3:0] button_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] settled_reg = 4'h0;
    logic [3:0] moved_reg   = 4'h0;
    logic [1:0] bounce_reg  = 2'h0;

    always_ff @(posedge clk_in) begin
        if (want_in !== settled_reg) begin
            settled_reg <= want_in;
            moved_reg   <= want_in ^ settled_reg;
            bounce_reg  <= 2'h3;
        end else if (bounce_reg != 2'h0) begin
            bounce_reg <= bounce_reg - 2'h1;
        end
    end

    // Contacts chatter for a few cycles after each change, shorter than the debounce window.
    assign button_out = settled_reg ^ (bounce_reg[0] ? moved_reg : 4'h0);
endmodule

// *** verification/tb_slot_status_display_sequencer.sv ***
/*
 * Self-checking bench for the slot status display sequencer.
 * Assumes the sssd_pkg constants and shortened timing parameters below.
 */
module tb_slot_status_display_sequencer
    import sssd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SCR = 50;
    localparam int LNG = 40;
    localparam int FLS = 8;

    logic        clk     = 1'b0;
    logic        resetn  = 1'b0;
    logic [3:0]  want    = 4'h0;
    logic [3:0]  btn;
    logic [7:0]  present = 8'h00;
    logic [7:0]  servo   = 8'h00;
    logic [7:0]  test    = 8'h00;
    logic [7:0]  alarm   = 8'h00;
    logic [63:0] anum    = 64'h0;
    logic        ifu_al  = 1'b0;
    logic [7:0]  ifu_num = 8'h00;
    logic [34:0] seg;
    logic [4:0]  dp;
    logic        scr_out;
    logic [3:0]  unit;
    logic [4:0]  expq[$];
    logic [4:0]  last    = 5'h00;
    int          gap     = 0;
    bit          scroll_chk = 1'b0;
    int          n_fail  = 0;
    int          n_tests = 0;
    int          plist[$];
    int          n;
    int          cur;
    logic [7:0]  p;
    logic [6:0]  sg;
    logic [34:0] snap;
    int unsigned rnd;

    initial forever #4 clk = ~clk;

    sssd_partner_model sssd_partner_model_inst (.clk_in(clk), .want_in(want), .button_out(btn));

    sssd_top #(.SCROLL_T(SCR), .LONG_T(LNG), .FLASH_T(FLS), .DEBOUNCE_T(3)) sssd_top_inst (
        .core_clk_in(clk), .resetn_in(resetn), .button_in(btn), .slot_present_in(present),
        .servo_enable_command_in(servo), .slot_test_in(test), .slot_alarm_in(alarm),
        .slot_alarm_num_in(anum), .ifu_alarm_in(ifu_al), .ifu_alarm_num_in(ifu_num),
        .seg_out(seg), .dp_out(dp), .unit_screen_out(scr_out), .shown_unit_out(unit));

    task automatic report_and_stop();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [34:0] got, input logic [34:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_view(input logic [4:0] got, input logic [4:0] exp);
        cmp_val(35'(got), 35'(exp));
    endtask

    function automatic logic [6:0] dig(input int i);
        return seg[i*7 +: 7];
    endfunction

    function automatic logic has_glyph(input logic [6:0] g);
        for (int i = 0; i < 5; i++) begin
            if (seg[i*7 +: 7] === g) return 1'b1;
        end
        return 1'b0;
    endfunction

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic press(input int b, input int hold);
        want[b] <= 1'b1;
        ticks(hold);
        want[b] <= 1'b0;
        ticks(20);
    endtask

    task automatic wait_q(input int lim);
        for (int k = 0; k < lim && expq.size() > 0; k++) @(posedge clk);
        if (expq.size() > 0) begin
            n_fail++;
            report_and_stop();
        end
    endtask

    // Samples one full flash period plus four cycles; blank samples are skipped for content.
    task automatic alarm_look(input logic [6:0] first, input bit same);
        int blank;
        int lit;
        blank = 0;
        lit = 0;
        ticks(6);
        repeat (2 * FLS + 4) begin
            @(posedge clk);
            if (seg === 35'h0) begin
                blank++;
            end else begin
                lit++;
                cmp_val(35'(dig(4)), 35'(first));
                cmp_val(35'(dig(3)), 35'(SEG_ALARM));
                cmp_val(35'(dig(1) === dig(0)), 35'(same));
            end
        end
        cmp_val(35'(blank > 0 && lit > 0), 35'h1);
    endtask

    // A view change with no note queued is compared with the old view and so fails.
    always @(posedge clk) begin
        if (!resetn) begin
            last <= 5'h00;
            gap <= 0;
        end else if ({scr_out, unit} !== last) begin
            last <= {scr_out, unit};
            gap <= 0;
            if (scroll_chk) cmp_val(35'(gap >= SCR - 4 && gap <= SCR + 4), 35'h1);
            cmp_view({scr_out, unit}, expq.size() > 0 ? expq.pop_front() : last);
        end else begin
            gap <= gap + 1;
        end
    end

    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        rnd = $urandom(84243);
        p = (rnd[7:0] | 8'h05) & 8'hfd;
        for (int i = 0; i < 8; i++) begin
            if (p[i]) plist.push_back(i + 1);
        end
        n = plist.size();
        foreach (plist[i]) expq.push_back(5'(plist[i]));
        expq.push_back(5'h00);
        expq.push_back(5'(plist[0]));
        ticks(1);
        present <= p;
        servo <= rnd[15:8];
        scroll_chk <= 1'b1;
        ticks(7);
        resetn <= 1'b1;
        wait_q(SCR * 12);
        scroll_chk <= 1'b0;
        press(BTN_SET, 20);
        ticks(3 * SCR);
        cmp_view({scr_out, unit}, 5'(plist[0]));
        cmp_val(35'(has_glyph(servo[plist[0]-1] ? SEG_ON_GLYPH : SEG_OFF_GLYPH)), 35'h1);
        for (int k = 1; k <= n; k++) begin
            expq.push_back(5'(plist[k % n]));
            press(BTN_UP, 20);
        end
        wait_q(50);
        expq.push_back(5'(plist[n-1]));
        press(BTN_DOWN, 20);
        wait_q(50);
        press(BTN_SET, 20);
        cur = plist[n-1];
        test[cur-1] <= 1'b1;
        for (int sv = 0; sv < 2; sv++) begin
            servo[cur-1] <= sv[0];
            ticks(6);
            cmp_val(35'(dig(3)), 35'(SEG_TEST));
            cmp_val(35'(dig(1)), 35'(sv[0] ? SEG_ON_GLYPH : SEG_OFF_GLYPH));
            cmp_val(35'(dp), 35'h01);
        end
        sg = dig(4);
        test[cur-1] <= 1'b0;
        anum[(cur-1)*8 +: 8] <= {rnd[19:16], rnd[19:16]};
        alarm[cur-1] <= 1'b1;
        alarm_look(sg, 1'b1);
        anum[(cur-1)*8 +: 8] <= {rnd[19:16], rnd[19:16] ^ 4'h1};
        alarm_look(sg, 1'b0);
        alarm[cur-1] <= 1'b0;
        ticks(6);
        cmp_val(35'(dig(3) === SEG_ALARM), 35'h0);
        resetn <= 1'b0;
        present <= 8'h00;
        ticks(8);
        resetn <= 1'b1;
        ticks(4);
        ifu_num <= {rnd[23:20], rnd[23:20]};
        ifu_al <= 1'b1;
        alarm_look(SEG_IFU, 1'b1);
        ifu_al <= 1'b0;
        ticks(4);
        expq.push_back(5'h10);
        press(BTN_MODE, LNG + 30);
        wait_q(50);
        for (int b = 1; b < 4; b++) begin
            snap = seg;
            press(b, 20);
            cmp_val(35'(seg !== snap), 35'h1);
        end
        ifu_al <= 1'b1;
        alarm_look(SEG_IFU, 1'b1);
        ifu_al <= 1'b0;
        expq.push_back(5'h00);
        press(BTN_MODE, LNG + 30);
        wait_q(50);
        report_and_stop();
    end
endmodule
